/* rtl/acal_pkg.sv */
// Shared constants and types for the adaptive threshold calibration pair.
// Assumes both ends run on one 50 MHz sys_clk with a synchronous reset.
package acal_pkg;
  localparam int NST = 12;               // Conversion stages
  localparam int DW = 16;                // Converter result width
  localparam int SW = 4;                 // Stage index width
  localparam int FW = 4;                 // Field selector width
  // Field selectors for the per-stage calibration store
  localparam logic [3:0] F_OFF_HI = 4'h0;
  localparam logic [3:0] F_OFF_LO = 4'h1;
  localparam logic [3:0] F_CLP_HI = 4'h2;
  localparam logic [3:0] F_CLP_LO = 4'h3;
  localparam logic [3:0] F_SENS = 4'h4;   // [7:4] upper, [3:0] lower_sensitivity_sel
  localparam logic [3:0] F_PEAK = 4'h5;   // [7:4] upper, [3:0] lower_peak_window
  localparam logic [3:0] F_AMB = 4'h6;    // ambient_baseline
  localparam logic [3:0] F_CTRL = 4'h7;   // [0] adaptive enable, global
  localparam logic [3:0] F_MAX = 4'h8;
  localparam logic [3:0] F_MIN = 4'h9;
  localparam logic [3:0] F_THR_HI = 4'ha;
  localparam logic [3:0] F_THR_LO = 4'hb;
  localparam logic [3:0] F_STAT = 4'hc;   // touch bits, read clears change flags
  // Sensitivity in 1/256 steps: code 0 -> 25%, code 8 -> 62.5%, code 15 -> 95.3%
  localparam logic [7:0] SENS_BASE = 8'h40;
  localparam logic [7:0] SENS_STEP = 8'h0c;
  localparam int SENS_SHIFT = 8;
  localparam int PEAK_SHIFT = 4;         // Peak window code is sixteenths of the gap
  localparam int AMB_SHIFT = 4;          // Ambient averaging weight 1/16
  localparam int OFF_SHIFT = 1;          // Offset moves by half the ambient drift
  localparam int AVG_SHIFT = 2;          // Peak average weight 1/4
  // Host start value for drift offsets: 205/256 of the clamp, about 80%
  localparam logic [7:0] INIT_PCT = 8'hcd;
  // Host APB map
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_RDATA = 8'h04;
  localparam logic [7:0] A_STAT = 8'h08;
  localparam int CMD_RD_BIT = 24;
  localparam logic [DW-1:0] RST_ZERO = 16'h0000;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_UPD = 2'b01,
    ST_THR = 2'b10
  } acal_st_t;
endpackage

/* rtl/acal_if.sv */
// Link between the host end and the calibration engine.
// One clock; the open-drain interrupt line is resolved here.
`timescale 1ns/1ps
interface acal_if;
  logic cfg_we;
  logic cfg_re;
  logic [3:0] cfg_stage;
  logic [3:0] cfg_field;
  logic [15:0] cfg_wdata;
  logic [15:0] rd_data;
  logic rd_valid;
  logic int_out;
  logic int_oe;
  logic int_n;
  // Pulled up when nobody drives low
  assign int_n = int_oe ? int_out : 1'b1;
  modport dev (input cfg_we, cfg_re, cfg_stage, cfg_field, cfg_wdata,
               output rd_data, rd_valid, int_out, int_oe);
  modport host (output cfg_we, cfg_re, cfg_stage, cfg_field, cfg_wdata,
                input rd_data, rd_valid, int_n);
endinterface

/* rtl/acal_dev.sv */
// Per-stage environmental calibration and adaptive threshold engine.
// Assumes conversions arrive as one-cycle strobes at least three cycles apart.
// Function
// - Drift offsets follow measured ambient drift
// - Trip levels recomputed after offsets change
// - Minimum average updates only inside lower window
// - Maximum average updates only inside upper window
// - Ambient baseline per stage from untouched samples
// - Lower offset starts near 80% of limit
// - Upper offset starts near 80% of limit
// - Upper limit bounds tracked maximum response
// - Lower limit bounds tracked minimum response
// - Trip levels referenced to ambient baseline
// - Trip levels are percentages of drift offsets
// - Adaptive mode uses recent average maximum
// - Sixteen sensitivity steps, 25% to 95.32%
// - Code 1000 gives about 62.51%
// - Smaller percentage trips closer to ambient
// - Host sets sensitivity once at startup
// - Host supplies initial offsets, engine adapts
// - Compensation runs on every untouched conversion
// - Interrupt low when trip status changes
//
// The APB interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module acal_dev (
  input wire logic sys_clk,
  input wire logic sys_rst,
  acal_if.dev lnk,
  input wire logic conv_valid,
  input wire logic [acal_pkg::SW-1:0] conv_stage,
  input wire logic [acal_pkg::DW-1:0] conv_result,
  output logic [acal_pkg::NST-1:0] touch_o,
  output logic busy_o
);
  import acal_pkg::*;

  typedef struct packed {
    acal_st_t st;
    logic [SW-1:0] stg;
    logic [DW-1:0] res;
    logic [NST-1:0][DW-1:0] amb;
    logic [NST-1:0][DW-1:0] off_hi;
    logic [NST-1:0][DW-1:0] off_lo;
    logic [NST-1:0][DW-1:0] clp_hi;
    logic [NST-1:0][DW-1:0] clp_lo;
    logic [NST-1:0][DW-1:0] max_avg;
    logic [NST-1:0][DW-1:0] min_avg;
    logic [NST-1:0][DW-1:0] thr_hi;
    logic [NST-1:0][DW-1:0] thr_lo;
    logic [NST-1:0][3:0] sens_hi;
    logic [NST-1:0][3:0] sens_lo;
    logic [NST-1:0][3:0] pk_hi;
    logic [NST-1:0][3:0] pk_lo;
    logic [NST-1:0] touch;
    logic [NST-1:0] chg;
    logic adapt;
    logic [DW-1:0] rdata;
    logic rvalid;
    logic int_oe;
  } acal_dev_t;

  acal_dev_t s_q, s_d;

  // Clamp a signed value into [0, lim]
  function automatic logic [DW-1:0] sat(input logic signed [17:0] x,
                                        input logic [DW-1:0] lim);
    logic signed [17:0] l;
    l = $signed({2'b00, lim});
    if (x < 18'sd0) sat = RST_ZERO;
    else if (x > l) sat = lim;
    else sat = x[DW-1:0];
  endfunction

  // Fraction in 1/256 of a sensitivity code
  function automatic logic [7:0] pct(input logic [3:0] code);
    logic [7:0] p;
    p = SENS_BASE + SENS_STEP * {4'h0, code};
    pct = p;
  endfunction

  // Next state of the engine
  always_comb begin
    logic signed [17:0] r, a, drift, ad, tmp, gap, win, dh;
    logic [23:0] prod;
    logic [DW-1:0] base;
    logic above, below, act;
    int unsigned i, w;
    s_d = s_q;
    r = '0;
    a = '0;
    drift = '0;
    ad = '0;
    tmp = '0;
    gap = '0;
    win = '0;
    dh = '0;
    prod = '0;
    base = '0;
    above = 1'b0;
    below = 1'b0;
    act = 1'b0;
    i = 32'(s_q.stg);
    w = 32'(lnk.cfg_stage);
    s_d.rvalid = 1'b0;
    // Status read clears change flags first so a same-cycle change still sets
    if (lnk.cfg_re && lnk.cfg_field == F_STAT) begin
      s_d.chg = '0;
    end
    case (s_q.st)
      ST_IDLE: begin
        if (conv_valid && 32'(conv_stage) < NST) begin
          s_d.stg = conv_stage;
          s_d.res = conv_result;
          s_d.st = ST_UPD;
        end
      end
      ST_UPD: begin
        r = $signed({2'b00, s_q.res});
        a = $signed({2'b00, s_q.amb[i]});
        above = s_q.res > s_q.thr_hi[i];
        below = s_q.res < s_q.thr_lo[i];
        act = above | below;
        s_d.touch[i] = act;
        if (act != s_q.touch[i]) s_d.chg[i] = 1'b1;
        if (!act) begin
          // Ambient only learns while untouched, so a finger never becomes ambient
          drift = (r - a) >>> AMB_SHIFT;
          ad = a + drift;
          s_d.amb[i] = ad[DW-1:0];
          dh = drift >>> OFF_SHIFT;
          tmp = $signed({2'b00, s_q.off_hi[i]}) - dh;
          s_d.off_hi[i] = sat(tmp, s_q.clp_hi[i]);
          tmp = $signed({2'b00, s_q.off_lo[i]}) + dh;
          s_d.off_lo[i] = sat(tmp, s_q.clp_lo[i]);
        end else if (above) begin
          gap = $signed({2'b00, s_q.max_avg[i]}) - a;
          win = (gap * $signed({14'h0, s_q.pk_hi[i]})) >>> PEAK_SHIFT;
          if (r >= $signed({2'b00, s_q.max_avg[i]}) - win) begin
            tmp = $signed({2'b00, s_q.max_avg[i]});
            tmp = tmp + ((r - tmp) >>> AVG_SHIFT);
            tmp = tmp - a;
            s_d.max_avg[i] = 16'(a + $signed({2'b00, sat(tmp, s_q.clp_hi[i])}));
          end
        end else begin
          gap = a - $signed({2'b00, s_q.min_avg[i]});
          win = (gap * $signed({14'h0, s_q.pk_lo[i]})) >>> PEAK_SHIFT;
          if (r <= $signed({2'b00, s_q.min_avg[i]}) + win) begin
            tmp = $signed({2'b00, s_q.min_avg[i]});
            tmp = tmp + ((r - tmp) >>> AVG_SHIFT);
            tmp = a - tmp;
            s_d.min_avg[i] = 16'(a - $signed({2'b00, sat(tmp, s_q.clp_lo[i])}));
          end
        end
        s_d.st = ST_THR;
      end
      ST_THR: begin
        // Trip levels follow whatever the update step just wrote
        a = $signed({2'b00, s_q.amb[i]});
        base = s_q.adapt ? 16'(s_q.max_avg[i] - s_q.amb[i]) : s_q.off_hi[i];
        prod = {8'h00, base} * {16'h0000, pct(s_q.sens_hi[i])};
        dh = $signed({2'b00, prod[23:SENS_SHIFT]});
        s_d.thr_hi[i] = sat(a + dh, 16'hffff);
        base = s_q.adapt ? 16'(s_q.amb[i] - s_q.min_avg[i]) : s_q.off_lo[i];
        prod = {8'h00, base} * {16'h0000, pct(s_q.sens_lo[i])};
        dh = $signed({2'b00, prod[23:SENS_SHIFT]});
        s_d.thr_lo[i] = sat(a - dh, 16'hffff);
        s_d.st = ST_IDLE;
      end
      default: s_d.st = ST_IDLE;
    endcase
    // Configuration write wins over the engine for the same field
    if (lnk.cfg_we && w < NST) begin
      case (lnk.cfg_field)
        F_OFF_HI: begin
          s_d.off_hi[w] = lnk.cfg_wdata;
          s_d.max_avg[w] = 16'(s_q.amb[w] + lnk.cfg_wdata);
        end
        F_OFF_LO: begin
          s_d.off_lo[w] = lnk.cfg_wdata;
          s_d.min_avg[w] = 16'(s_q.amb[w] - lnk.cfg_wdata);
        end
        F_CLP_HI: s_d.clp_hi[w] = lnk.cfg_wdata;
        F_CLP_LO: s_d.clp_lo[w] = lnk.cfg_wdata;
        F_SENS: begin
          s_d.sens_hi[w] = lnk.cfg_wdata[7:4];
          s_d.sens_lo[w] = lnk.cfg_wdata[3:0];
        end
        F_PEAK: begin
          s_d.pk_hi[w] = lnk.cfg_wdata[7:4];
          s_d.pk_lo[w] = lnk.cfg_wdata[3:0];
        end
        F_AMB: s_d.amb[w] = lnk.cfg_wdata;
        F_CTRL: s_d.adapt = lnk.cfg_wdata[0];
        default: ;
      endcase
    end
    // Readback, one cycle after the strobe
    if (lnk.cfg_re) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = RST_ZERO;
      if (lnk.cfg_field == F_STAT) s_d.rdata = 16'(s_q.touch);
      else if (lnk.cfg_field == F_CTRL) s_d.rdata = {15'h0000, s_q.adapt};
      else if (w < NST) begin
        case (lnk.cfg_field)
          F_OFF_HI: s_d.rdata = s_q.off_hi[w];
          F_OFF_LO: s_d.rdata = s_q.off_lo[w];
          F_CLP_HI: s_d.rdata = s_q.clp_hi[w];
          F_CLP_LO: s_d.rdata = s_q.clp_lo[w];
          F_SENS: s_d.rdata = {8'h00, s_q.sens_hi[w], s_q.sens_lo[w]};
          F_PEAK: s_d.rdata = {8'h00, s_q.pk_hi[w], s_q.pk_lo[w]};
          F_AMB: s_d.rdata = s_q.amb[w];
          F_MAX: s_d.rdata = s_q.max_avg[w];
          F_MIN: s_d.rdata = s_q.min_avg[w];
          F_THR_HI: s_d.rdata = s_q.thr_hi[w];
          F_THR_LO: s_d.rdata = s_q.thr_lo[w];
          default: s_d.rdata = RST_ZERO;
        endcase
      end
    end
    s_d.int_oe = |s_d.chg;
  end

  // State register; trip levels reset wide open so nothing trips before setup
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.thr_hi <= '1;
    end else begin
      s_q <= s_d;
    end
  end

  assign lnk.rd_data = s_q.rdata;
  assign lnk.rd_valid = s_q.rvalid;
  assign lnk.int_out = 1'b0;
  assign lnk.int_oe = s_q.int_oe;
  assign touch_o = s_q.touch;
  assign busy_o = s_q.st != ST_IDLE;
endmodule

/* rtl/acal_host.sv */
// Host end: APB registers that turn software commands into link strobes.
// Assumes an APB master on sys_clk and the engine on the far side of acal_if.
`timescale 1ns/1ps
module acal_host (
  input wire logic sys_clk,
  input wire logic sys_rst,
  acal_if.host lnk,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq_o
);
  import acal_pkg::*;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic we;
    logic re;
    logic [3:0] stage;
    logic [3:0] field;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic rd_wait;
    logic follow;
    logic [3:0] f_field;
    logic [15:0] f_data;
    logic locked;
    logic refused;
    logic irq;
  } acal_host_t;

  acal_host_t s_q, s_d;

  // Next state: one wait state per APB access, strobes last one cycle
  always_comb begin
    logic [23:0] prod;
    s_d = s_q;
    prod = '0;
    s_d.we = 1'b0;
    s_d.re = 1'b0;
    s_d.pready = 1'b0;
    s_d.irq = ~lnk.int_n;
    if (lnk.rd_valid) begin
      s_d.rdata = lnk.rd_data;
      s_d.rd_wait = 1'b0;
    end
    // Offset follows its clamp at about 80% of it
    if (s_q.follow) begin
      s_d.we = 1'b1;
      s_d.field = s_q.f_field;
      s_d.wdata = s_q.f_data;
      s_d.follow = 1'b0;
    end
    if (psel && penable && !s_q.pready) begin
      s_d.pready = 1'b1;
      s_d.pslverr = 1'b0;
      s_d.prdata = 32'h0000_0000;
      case (paddr)
        A_CMD: begin
          if (pwrite && !s_q.follow && !s_q.rd_wait) begin
            s_d.stage = pwdata[19:16];
            s_d.field = pwdata[23:20];
            s_d.wdata = pwdata[15:0];
            if (pwdata[CMD_RD_BIT]) begin
              s_d.re = 1'b1;
              s_d.rd_wait = 1'b1;
            end else if (pwdata[23:20] == F_SENS && s_q.locked) begin
              s_d.refused = 1'b1;
            end else begin
              s_d.we = 1'b1;
              if (pwdata[23:20] == F_SENS) s_d.locked = 1'b1;
              prod = {8'h00, pwdata[15:0]} * {16'h0000, INIT_PCT};
              if (pwdata[23:20] == F_CLP_HI) begin
                s_d.follow = 1'b1;
                s_d.f_field = F_OFF_HI;
                s_d.f_data = prod[23:8];
              end else if (pwdata[23:20] == F_CLP_LO) begin
                s_d.follow = 1'b1;
                s_d.f_field = F_OFF_LO;
                s_d.f_data = prod[23:8];
              end
            end
          end else if (pwrite) begin
            s_d.refused = 1'b1;
          end
        end
        A_RDATA: s_d.prdata = {16'h0000, s_q.rdata};
        A_STAT: begin
          s_d.prdata = {28'h0000000, s_q.refused, s_q.locked, s_q.irq,
                        s_q.follow | s_q.rd_wait};
          if (!pwrite) s_d.refused = 1'b0;
        end
        default: s_d.pslverr = 1'b1;
      endcase
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) s_q <= '0;
    else s_q <= s_d;
  end

  assign lnk.cfg_we = s_q.we;
  assign lnk.cfg_re = s_q.re;
  assign lnk.cfg_stage = s_q.stage;
  assign lnk.cfg_field = s_q.field;
  assign lnk.cfg_wdata = s_q.wdata;
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irq_o = s_q.irq;
endmodule

/* verification/acal_checker.sv */
// Checker for the link between the host end and the calibration engine.
// Assumes one sys_clk domain and a synchronous active-high sys_rst.
`timescale 1ns/1ps
module acal_checker
  import acal_pkg::*;
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic cfg_we,
  input wire logic cfg_re,
  input wire logic [3:0] cfg_stage,
  input wire logic [3:0] cfg_field,
  input wire logic [15:0] cfg_wdata,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic int_out,
  input wire logic int_oe,
  input wire logic int_n
);
  logic per_stage;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  // Fields that live once per stage; the control and status words are global
  assign per_stage = (cfg_field <= F_AMB) || (cfg_field >= F_MAX && cfg_field <= F_THR_LO);

  // Readback handshake on the link
  AST_RD_ANSWER: assert property (cfg_re |=> rd_valid)
    else $error("read strobe not answered next cycle");
  AST_RD_CAUSE: assert property (rd_valid |-> $past(cfg_re))
    else $error("readback without a read strobe");
  AST_RD_PULSE: assert property (rd_valid && !cfg_re |=> !rd_valid)
    else $error("readback valid held too long");
  AST_RANGE_ZERO: assert property (cfg_re && cfg_stage >= 4'hc && per_stage |=>
    rd_data == 16'h0000)
    else $error("stage beyond range returned data");
  // Host strobes: one at a time, spaced by the bus handshake; only a clamp write
  // is followed at once by its own offset write
  AST_STROBE_EXCL: assert property (!(cfg_we && cfg_re))
    else $error("write and read strobe together");
  AST_STROBE_GAP: assert property (cfg_re |=> !(cfg_we || cfg_re) [*2])
    else $error("strobe too soon after a read strobe");
  AST_STROBE_WRGAP: assert property (cfg_we |=> !cfg_re [*2])
    else $error("read strobe too soon after a write strobe");
  AST_FOLLOW_ONE: assert property (cfg_we ##1 cfg_we |=> !(cfg_we || cfg_re))
    else $error("more than one write follows a clamp write");
  // Open-drain line: only ever pulled low, and released only by a status read
  AST_INT_LEVEL: assert property (int_oe |-> !int_out && !int_n)
    else $error("interrupt line not low while driven");
  AST_INT_CLEAR: assert property ($fell(int_oe) |-> $past(cfg_re && cfg_field == F_STAT))
    else $error("interrupt released without status read");
  AST_INT_STAYS: assert property (int_oe && !cfg_re |=> int_oe)
    else $error("interrupt dropped on its own");

  cover property (cfg_re ##1 rd_valid);
  cover property ($rose(int_oe));
  cover property ($fell(int_oe));
  cover property (cfg_we ##1 cfg_we);
endmodule

/* verification/tb_adaptive_threshold_calibration.sv */
// Bench for the calibration pair: APB on the host end, conversions into the engine.
// Assumes the rtl package, interface, both ends and the link checker are compiled first.
`timescale 1ns/1ps
module tb_adaptive_threshold_calibration;
  import acal_pkg::*;
  logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq_o, conv_valid, busy_o, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [3:0] conv_stage;
  logic [15:0] conv_result, amb, ohi, olo, mx, mn, v;
  logic [NST-1:0] touch_o;
  int n_errors = 0;
  int tests_run = 0;

  acal_if i_acal_if ();
  acal_host i_acal_host (.sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(i_acal_if.host),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq_o(irq_o));
  acal_dev i_acal_dev (.sys_clk(sys_clk), .sys_rst(sys_rst), .lnk(i_acal_if.dev),
    .conv_valid(conv_valid), .conv_stage(conv_stage), .conv_result(conv_result),
    .touch_o(touch_o), .busy_o(busy_o));
  acal_checker i_acal_checker (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .cfg_we(i_acal_if.cfg_we), .cfg_re(i_acal_if.cfg_re), .cfg_stage(i_acal_if.cfg_stage),
    .cfg_field(i_acal_if.cfg_field), .cfg_wdata(i_acal_if.cfg_wdata),
    .rd_data(i_acal_if.rd_data), .rd_valid(i_acal_if.rd_valid),
    .int_out(i_acal_if.int_out), .int_oe(i_acal_if.int_oe), .int_n(i_acal_if.int_n));

  // 50 MHz system clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; waits on pready rather than assuming the wait state
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  // Poll busy before each command; a command while busy would be dropped
  task automatic idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 50);
    if (r[0] !== 1'b0) n_errors++;
  endtask

  task automatic cw(input logic [3:0] f, input logic [3:0] s, input logic [15:0] d);
    idle();
    apb(1'b1, A_CMD, {8'h00, f, s, d});
  endtask

  task automatic cr(input logic [3:0] f, input logic [3:0] s);
    idle();
    apb(1'b1, A_CMD, {7'h00, 1'b1, f, s, 16'h0000});
    idle();
    apb(1'b0, A_RDATA, 32'h0);
    v = r[15:0];
  endtask

  task automatic conv(input logic [3:0] s, input logic [15:0] d);
    int n;
    n = 0;
    while (busy_o !== 1'b0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (busy_o !== 1'b0) n_errors++;
    conv_valid <= 1'b1;
    conv_stage <= s;
    conv_result <= d;
    @(posedge sys_clk);
    conv_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  function automatic logic [15:0] pct(input logic [15:0] x, input logic [3:0] c);
    return 16'((32'(x) * (32'(SENS_BASE) + 32'(SENS_STEP) * 32'(c))) >> SENS_SHIFT);
  endfunction

  // Stage 0 trip levels from its own state; upper code 8, lower code 1
  task automatic thr(input logic ad);
    cr(F_AMB, 4'h0);
    amb = v;
    cr(F_OFF_HI, 4'h0);
    ohi = v;
    cr(F_OFF_LO, 4'h0);
    olo = v;
    cr(F_MAX, 4'h0);
    mx = v;
    cr(F_MIN, 4'h0);
    mn = v;
    cr(F_THR_HI, 4'h0);
    chk(v, ad ? 16'(amb + pct(mx - amb, 4'h8)) : 16'(amb + pct(ohi, 4'h8)));
    cr(F_THR_LO, 4'h0);
    chk(v, ad ? 16'(amb - pct(amb - mn, 4'h1)) : 16'(amb - pct(olo, 4'h1)));
  endtask

  task automatic final_report();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs under a thousand cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    final_report();
  end

  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    conv_valid = 1'b0;
    conv_stage = 4'h0;
    conv_result = 16'h0000;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    // Reset state and an unmapped address
    apb(1'b0, A_STAT, 32'h0);
    chk(r, 32'h0);
    apb(1'b0, 8'h0c, 32'h0);
    chk(e, 1'b1);
    cr(F_THR_HI, 4'h0);
    chk(v, 16'hffff);
    // Clamps first; the offsets follow at 205/256 of them
    cw(F_AMB, 4'h0, 16'h1000);
    cw(F_CLP_HI, 4'h0, 16'h0100);
    cw(F_CLP_LO, 4'h0, 16'h0100);
    cr(F_OFF_HI, 4'h0);
    chk(v, 16'h00cd);
    cr(F_OFF_LO, 4'h0);
    chk(v, 16'h00cd);
    cw(F_OFF_HI, 4'h0, 16'h00c0);
    cw(F_OFF_LO, 4'h0, 16'h0060);
    // Sensitivity is taken once; a second write is refused
    cw(F_SENS, 4'h0, 16'h0081);
    cw(F_SENS, 4'h0, 16'h00ff);
    apb(1'b0, A_STAT, 32'h0);
    chk(r[3:2], 2'b11);
    cr(F_SENS, 4'h0);
    chk(v, 16'h0081);
    // Untouched conversion at ambient refreshes the trip levels
    conv(4'h0, 16'h1000);
    chk(touch_o, '0);
    thr(1'b0);
    cr(F_THR_HI, 4'h0);
    chk(v, 16'h1078);
    // Above the upper level, then below the lower level
    conv(4'h0, 16'h1079);
    chk({irq_o, i_acal_if.int_n, touch_o[0]}, 3'b101);
    cr(F_STAT, 4'h0);
    chk(v, 16'h0001);
    chk(i_acal_if.int_n, 1'b1);
    conv(4'h0, 16'h0fe3);
    chk(touch_o[0], 1'b1);
    cr(F_MAX, 4'h0);
    chk(v, 16'h10c0);
    cr(F_MIN, 4'h0);
    chk(v, 16'h0fa0);
    // Exactly at the upper level is no contact; ambient and offsets drift
    conv(4'h0, 16'h1078);
    chk(touch_o[0], 1'b0);
    thr(1'b0);
    chk(amb, 16'h1007);
    chk(ohi < 16'h00c0 && olo > 16'h0060, 1'b1);
    // Adaptive levels follow the tracked peaks
    cw(F_CTRL, 4'h0, 16'h0001);
    conv(4'h0, amb);
    thr(1'b1);
    // Peak windows at half the gap: each tracked average moves a quarter of the way
    cw(F_PEAK, 4'h0, 16'h0088);
    conv(4'h0, 16'h1090);
    cr(F_MAX, 4'h0);
    chk(v, 16'h10b4);
    cr(F_THR_HI, 4'h0);
    chk(v, 16'h1073);
    conv(4'h0, 16'h0f90);
    cr(F_MIN, 4'h0);
    chk(v, 16'h0f9c);
    // Other stages keep their own state; stage 12 does not exist
    cw(F_AMB, 4'hc, 16'h1234);
    cr(F_AMB, 4'hc);
    chk(v, 16'h0000);
    cr(F_AMB, 4'h1);
    chk(v, 16'h0000);
    final_report();
  end
endmodule
